// file: rtl/pin_mux.sv
// Purpose: I/O strobes and port A/B/C function mux with register access
// Assumes: pins pass four flops; register port reads one cycle later
// Notes:   serial and slave port units sit outside and use these lines
`timescale 1ns/1ps

module pin_mux (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // core bus cycle kind, slave side data and serial unit outputs
  input  pin_mux_pkg::io_cycle_t    io_cycle,
  input  wire logic                 slave_attention_req,
  input  wire logic [7:0]           slave_rd_data,
  input  wire logic                 sclk_a_out,
  input  wire logic                 sclk_b_out,
  input  wire logic [3:0]           ser_txd,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  // strobes
  output logic                      io_read_strobe_n,
  output logic                      io_write_strobe_n,
  output logic                      io_buffer_enable_n,
  // port pins
  input  wire logic [7:0]           port_a_lines_i,
  output logic      [7:0]           port_a_lines_o,
  output logic      [7:0]           port_a_lines_oe,
  input  wire logic [7:0]           port_b_lines_i,
  output logic      [7:0]           port_b_lines_o,
  output logic      [7:0]           port_b_lines_oe,
  input  wire logic [7:0]           port_c_lines_i,
  output logic      [7:0]           port_c_lines_o,
  // synchronised pins to inner units
  output logic [7:0]                slave_wr_data,
  output logic                      slave_reg_addr_hi,
  output logic                      slave_reg_addr_lo,
  output logic                      slave_rd_strobe_n,
  output logic                      slave_wr_strobe_n,
  output logic                      sclk_a_in,
  output logic                      sclk_b_in,
  output logic [3:0]                ser_rxd
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [7:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_q;
  logic [7:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_q;
  logic [7:0] pc_s1_q, pc_s2_q, pc_s3_q, pc_q;

  // accept a change once stages two and three agree
  function automatic logic [7:0] settle(input logic [7:0] s2, input logic [7:0] s3,
                                        input logic [7:0] cur);
    settle = (s2 & s3) | (cur & (s2 ^ s3));
  endfunction

  logic [7:0] pa_d, pb_d, pc_d;
  assign pa_d = settle(pa_s2_q, pa_s3_q, pa_q);
  assign pb_d = settle(pb_s2_q, pb_s3_q, pb_q);
  assign pc_d = settle(pc_s2_q, pc_s3_q, pc_q);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pa_s1_q <= pin_mux_pkg::RST_BYTE;
      pa_s2_q <= pin_mux_pkg::RST_BYTE;
      pa_s3_q <= pin_mux_pkg::RST_BYTE;
      pa_q    <= pin_mux_pkg::RST_BYTE;
      pb_s1_q <= pin_mux_pkg::RST_BYTE;
      pb_s2_q <= pin_mux_pkg::RST_BYTE;
      pb_s3_q <= pin_mux_pkg::RST_BYTE;
      pb_q    <= pin_mux_pkg::RST_BYTE;
      pc_s1_q <= pin_mux_pkg::RST_BYTE;
      pc_s2_q <= pin_mux_pkg::RST_BYTE;
      pc_s3_q <= pin_mux_pkg::RST_BYTE;
      pc_q    <= pin_mux_pkg::RST_BYTE;
    end
    else
    begin
      pa_s1_q <= port_a_lines_i;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      pa_q    <= pa_d;
      pb_s1_q <= port_b_lines_i;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
      pb_q    <= pb_d;
      pc_s1_q <= port_c_lines_i;
      pc_s2_q <= pc_s1_q;
      pc_s3_q <= pc_s2_q;
      pc_q    <= pc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] pa_data_q, pa_dir_q, pb_data_q, pc_data_q, pc_func_q;
  logic [5:0] ctrl_q;

  logic sel_pa_data, sel_pa_dir, sel_pb_data, sel_pc_data, sel_pc_func, sel_ctrl;
  assign sel_pa_data = reg_wr && (reg_addr == pin_mux_pkg::REG_PA_DATA);
  assign sel_pa_dir  = reg_wr && (reg_addr == pin_mux_pkg::REG_PA_DIR);
  assign sel_pb_data = reg_wr && (reg_addr == pin_mux_pkg::REG_PB_DATA);
  assign sel_pc_data = reg_wr && (reg_addr == pin_mux_pkg::REG_PC_DATA);
  assign sel_pc_func = reg_wr && (reg_addr == pin_mux_pkg::REG_PC_FUNC);
  assign sel_ctrl    = reg_wr && (reg_addr == pin_mux_pkg::REG_CTRL);

  logic wr_en, slave_en, sclka_en, sclkb_en;
  assign wr_en    = ctrl_q[pin_mux_pkg::CTRL_WR_EN];
  assign slave_en = ctrl_q[pin_mux_pkg::CTRL_SLAVE_EN];
  assign sclka_en = ctrl_q[pin_mux_pkg::CTRL_SCLKA_EN];
  assign sclkb_en = ctrl_q[pin_mux_pkg::CTRL_SCLKB_EN];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pa_data_q <= pin_mux_pkg::RST_BYTE;
      pa_dir_q  <= pin_mux_pkg::RST_BYTE;
      pb_data_q <= pin_mux_pkg::RST_BYTE;
      pc_data_q <= pin_mux_pkg::RST_BYTE;
      pc_func_q <= pin_mux_pkg::RST_BYTE;
      ctrl_q    <= pin_mux_pkg::RST_CTRL;
    end
    else
    begin
      if (sel_pa_data) pa_data_q <= reg_wdata;
      if (sel_pa_dir)  pa_dir_q  <= reg_wdata;
      if (sel_pb_data) pb_data_q <= reg_wdata;
      if (sel_pc_data) pc_data_q <= reg_wdata;
      if (sel_pc_func) pc_func_q <= reg_wdata;
      if (sel_ctrl)    ctrl_q    <= reg_wdata[5:0];
    end
  end

  logic [7:0] rd_mux;
  assign rd_mux =
    (reg_addr == pin_mux_pkg::REG_PA_DATA) ? pa_data_q :
    (reg_addr == pin_mux_pkg::REG_PA_DIR)  ? pa_dir_q  :
    (reg_addr == pin_mux_pkg::REG_PB_DATA) ? pb_q      :
    (reg_addr == pin_mux_pkg::REG_PC_DATA) ? pc_q      :
    (reg_addr == pin_mux_pkg::REG_PC_FUNC) ? pc_func_q :
    (reg_addr == pin_mux_pkg::REG_CTRL)    ? {2'h0, ctrl_q} :
    (reg_addr == pin_mux_pkg::REG_PA_PIN)  ? pa_q      : pin_mux_pkg::RD_ZERO;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= pin_mux_pkg::RD_ZERO;
    else
      reg_rdata <= reg_rd ? rd_mux : pin_mux_pkg::RD_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes

  logic is_rd, is_wr;
  assign is_rd = (io_cycle == pin_mux_pkg::CYC_IO_RD);
  assign is_wr = (io_cycle == pin_mux_pkg::CYC_IO_WR);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_read_strobe_n   <= 1'b1;
      io_write_strobe_n  <= 1'b1;
      io_buffer_enable_n <= 1'b1;
    end
    else
    begin
      io_read_strobe_n   <= !is_rd;
      io_write_strobe_n  <= !(is_wr && wr_en);
      io_buffer_enable_n <= !(is_rd || is_wr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  logic slave_rd_n, slave_sel;
  assign slave_rd_n = pb_q[pin_mux_pkg::PB_RD];
  assign slave_sel  = slave_en && !slave_rd_n;

  logic [7:0] pa_o_d, pa_oe_d, pb_o_d, pb_oe_d, pc_o_d;
  assign pa_o_d  = slave_en ? slave_rd_data : pa_data_q;
  assign pa_oe_d = slave_en ? {8{slave_sel}} : pa_dir_q;

  assign pb_o_d = {slave_en ? !slave_attention_req : pb_data_q[pin_mux_pkg::PB_ATTN],
                   pb_data_q[pin_mux_pkg::PB_OUT6], 4'h0, sclk_a_out, sclk_b_out};
  assign pb_oe_d = {2'h3, 4'h0,
                    sclka_en && ctrl_q[pin_mux_pkg::CTRL_SCLKA_OUT],
                    sclkb_en && ctrl_q[pin_mux_pkg::CTRL_SCLKB_OUT]};

  logic [7:0] pc_tx;
  assign pc_tx  = {1'b0, ser_txd[0], 1'b0, ser_txd[1], 1'b0, ser_txd[2], 1'b0, ser_txd[3]};
  assign pc_o_d = ((pc_func_q & pc_tx) | (~pc_func_q & pc_data_q)) & pin_mux_pkg::PC_OUT_MASK;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_lines_o  <= pin_mux_pkg::RST_BYTE;
      port_a_lines_oe <= pin_mux_pkg::RST_BYTE;
      port_b_lines_o  <= pin_mux_pkg::RST_BYTE;
      port_b_lines_oe <= pin_mux_pkg::PB_RST_OE;
      port_c_lines_o  <= pin_mux_pkg::RST_BYTE;
    end
    else
    begin
      port_a_lines_o  <= pa_o_d;
      port_a_lines_oe <= pa_oe_d;
      port_b_lines_o  <= pb_o_d;
      port_b_lines_oe <= pb_oe_d;
      port_c_lines_o  <= pc_o_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inner unit feeds

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_wr_data     <= pin_mux_pkg::RST_BYTE;
      slave_reg_addr_hi <= 1'b0;
      slave_reg_addr_lo <= 1'b0;
      slave_rd_strobe_n <= 1'b1;
      slave_wr_strobe_n <= 1'b1;
      sclk_a_in         <= 1'b0;
      sclk_b_in         <= 1'b0;
      ser_rxd           <= 4'h0;
    end
    else
    begin
      slave_wr_data     <= pa_q;
      slave_reg_addr_hi <= pb_q[pin_mux_pkg::PB_ADDR_H];
      slave_reg_addr_lo <= pb_q[pin_mux_pkg::PB_ADDR_L];
      slave_rd_strobe_n <= !(slave_en && !pb_q[pin_mux_pkg::PB_RD]);
      slave_wr_strobe_n <= !(slave_en && !pb_q[pin_mux_pkg::PB_WR]);
      sclk_a_in         <= pb_q[pin_mux_pkg::PB_SCLKA];
      sclk_b_in         <= pb_q[pin_mux_pkg::PB_SCLKB];
      ser_rxd           <= {pc_q[1], pc_q[3], pc_q[5], pc_q[7]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_rd_strobe;
    @(posedge clk_sys) disable iff (!rst_n)
      is_rd |=> !io_read_strobe_n && !io_buffer_enable_n;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");

  property p_wr_strobe;
    @(posedge clk_sys) disable iff (!rst_n)
      (is_wr && wr_en) |=> !io_write_strobe_n;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");

  property p_wr_gate;
    @(posedge clk_sys) disable iff (!rst_n)
      !io_write_strobe_n |-> $past(wr_en) && $past(is_wr);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write strobe ungated");

  property p_io_buffer_enable_n;
    @(posedge clk_sys) disable iff (!rst_n)
      !io_buffer_enable_n |-> $past(is_rd) || $past(is_wr);
  endproperty
  a_io_buffer_enable_n: assert property (p_io_buffer_enable_n) else $error("buffer enable outside I/O");

  property p_pb_dir;
    @(posedge clk_sys) disable iff (!rst_n)
      port_b_lines_oe[7:2] == 6'h30;
  endproperty
  a_pb_dir: assert property (p_pb_dir) else $error("port B direction wrong");

  property p_pc_odd;
    @(posedge clk_sys) disable iff (!rst_n)
      (port_c_lines_o & ~pin_mux_pkg::PC_OUT_MASK) == 8'h00;
  endproperty
  a_pc_odd: assert property (p_pc_odd) else $error("odd port C driven");

  property p_slave_a;
    @(posedge clk_sys) disable iff (!rst_n)
      (slave_en && $past(slave_en) && |port_a_lines_oe) |-> $past(slave_sel);
  endproperty
  a_slave_a: assert property (p_slave_a) else $error("port A driven without read");

  property p_sclk_oe;
    @(posedge clk_sys) disable iff (!rst_n)
      port_b_lines_oe[1] |-> $past(sclka_en);
  endproperty
  a_sclk_oe: assert property (p_sclk_oe) else $error("clock line driven unset");

  property p_pc_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && reg_addr == pin_mux_pkg::REG_PC_DATA) |=> reg_rdata == $past(pc_q);
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("port C read wrong");

endmodule

// file: rtl/pin_mux_pkg.sv
// Purpose: shared constants for the strobe and port A/B/C pin mux
// Assumes: 10 MHz system clock, active-low asynchronous reset
// Notes:   register offsets are word addresses on the plain register port
package pin_mux_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [3:0] REG_PA_DATA = 4'h0;
  localparam logic [3:0] REG_PA_DIR  = 4'h1;
  localparam logic [3:0] REG_PB_DATA = 4'h2;
  localparam logic [3:0] REG_PC_DATA = 4'h3;
  localparam logic [3:0] REG_PC_FUNC = 4'h4;
  localparam logic [3:0] REG_CTRL    = 4'h5;
  localparam logic [3:0] REG_PA_PIN  = 4'h6;

  // control register fields
  localparam int unsigned CTRL_WR_EN    = 0;
  localparam int unsigned CTRL_SLAVE_EN = 1;
  localparam int unsigned CTRL_SCLKA_EN = 2;
  localparam int unsigned CTRL_SCLKB_EN = 3;
  localparam int unsigned CTRL_SCLKA_OUT = 4;
  localparam int unsigned CTRL_SCLKB_OUT = 5;

  // port B bit positions
  localparam int unsigned PB_ATTN   = 7;
  localparam int unsigned PB_OUT6   = 6;
  localparam int unsigned PB_ADDR_H = 5;
  localparam int unsigned PB_ADDR_L = 4;
  localparam int unsigned PB_RD     = 3;
  localparam int unsigned PB_WR     = 2;
  localparam int unsigned PB_SCLKA  = 1;
  localparam int unsigned PB_SCLKB  = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [7:0] RD_ZERO  = 8'h00;
  // port B output-only bits drive zero from reset on
  localparam logic [7:0] PB_RST_OE = 8'hC0;

  // even port C bits are outputs, odd bits inputs
  localparam logic [7:0] PC_OUT_MASK = 8'h55;

  // bus cycle kinds from the core
  typedef enum logic [1:0] {
    CYC_NONE,
    CYC_IO_RD,
    CYC_IO_WR
  } io_cycle_t;

endpackage

// file: dv/io_master_model.sv
// Purpose: far-side slave-port master and serial clock peer
// Assumes: master strobes active low, no pulls on port A
// Notes:   released port A lines show the inverse of their last level
`timescale 1ns/1ps

module io_master_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] port_a_o,
  input  wire logic [7:0] port_a_oe,
  input  wire logic [7:0] port_b_o,
  input  wire logic [7:0] port_b_oe,
  input  wire logic       mst_drive_a,
  input  wire logic [7:0] mst_a_data,
  input  wire logic       mst_rd_n,
  input  wire logic       mst_wr_n,
  input  wire logic [1:0] mst_addr,
  input  wire logic [1:0] sclk_peer,
  output logic      [7:0] port_a_i,
  output logic      [7:0] port_b_i
);
  logic [7:0] last_a_q = 8'h00;
  logic [7:0] a_wire;
  //////////////////////////////////////////////////////////////////////////////
  // port A wire from device, master or float
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (port_a_oe[i]) a_wire[i] = port_a_o[i];
      else if (mst_drive_a) a_wire[i] = mst_a_data[i];
      else a_wire[i] = ~last_a_q[i];
    end
  end
  always_ff @(posedge clk_sys) last_a_q <= a_wire;
  assign port_a_i = a_wire;
  //////////////////////////////////////////////////////////////////////////////
  // master drives strobes
  assign port_b_i = {port_b_o[7:6], mst_addr, mst_rd_n, mst_wr_n,
                     port_b_oe[1] ? port_b_o[1] : sclk_peer[1],
                     port_b_oe[0] ? port_b_o[0] : sclk_peer[0]};
endmodule

// file: dv/pin_mux_test.sv
// Purpose: self-checking bench for the pin mux
// Assumes: slave master and clock peer in io_master_model
// Notes:   pin changes get eight cycles to pass the synchronisers
`timescale 1ns/1ps

module pin_mux_test;
  logic                   clk_sys = 1'b0;
  logic                   rst_n;
  pin_mux_pkg::io_cycle_t io_cycle;
  logic [7:0]             slave_rd_data, reg_wdata, reg_rdata, pa_i, pa_o, pa_oe;
  logic [7:0]             pb_i, pb_o, pb_oe, pc_i, pc_o, slave_wr_data, mst_a_data;
  logic [3:0]             ser_txd, reg_addr, ser_rxd;
  logic                   attn_req, sclk_a_out, sclk_b_out, reg_wr, reg_rd, rd_n, wr_n;
  logic                   buf_n, s_hi, s_lo, s_rd_n, s_wr_n, sa_in, sb_in;
  logic                   mst_drive_a, mst_rd_n, mst_wr_n;
  logic [1:0]             mst_addr, sclk_peer;
  int                     n_errors = 0;
  int                     samples_checked = 0;

  always #50 clk_sys = ~clk_sys;

  pin_mux dut (.clk_sys(clk_sys), .rst_n(rst_n), .io_cycle(io_cycle),
    .slave_attention_req(attn_req), .slave_rd_data(slave_rd_data),
    .sclk_a_out(sclk_a_out), .sclk_b_out(sclk_b_out), .ser_txd(ser_txd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
    .io_buffer_enable_n(buf_n), .port_a_lines_i(pa_i), .port_a_lines_o(pa_o),
    .port_a_lines_oe(pa_oe), .port_b_lines_i(pb_i), .port_b_lines_o(pb_o),
    .port_b_lines_oe(pb_oe), .port_c_lines_i(pc_i), .port_c_lines_o(pc_o),
    .slave_wr_data(slave_wr_data), .slave_reg_addr_hi(s_hi), .slave_reg_addr_lo(s_lo),
    .slave_rd_strobe_n(s_rd_n), .slave_wr_strobe_n(s_wr_n), .sclk_a_in(sa_in),
    .sclk_b_in(sb_in), .ser_rxd(ser_rxd));

  io_master_model partner (.clk_sys(clk_sys), .port_a_o(pa_o), .port_a_oe(pa_oe),
    .port_b_o(pb_o), .port_b_oe(pb_oe), .mst_drive_a(mst_drive_a),
    .mst_a_data(mst_a_data), .mst_rd_n(mst_rd_n), .mst_wr_n(mst_wr_n),
    .mst_addr(mst_addr), .sclk_peer(sclk_peer), .port_a_i(pa_i), .port_b_i(pb_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(name, exp, reg_rdata);
    @(posedge clk_sys);
  endtask
  task automatic strobe(input pin_mux_pkg::io_cycle_t c, input logic [7:0] exp);
    io_cycle <= c;
    look(1);
    chk("rd_wr_buf", exp, {5'h00, rd_n, wr_n, buf_n});
    @(posedge clk_sys);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    look(1);
    chk("pa_oe", 8'h00, pa_oe);
    chk("pb_o76", 8'h00, {6'h00, pb_o[7:6]});
    chk("pb_oe", 8'hC0, pb_oe);
    @(posedge clk_sys);
  endtask
  task automatic t_strobes;
    strobe(pin_mux_pkg::CYC_IO_RD, 8'h02);
    strobe(pin_mux_pkg::CYC_IO_WR, 8'h06);
    io_cycle <= pin_mux_pkg::CYC_NONE;
    wr(pin_mux_pkg::REG_CTRL, 8'h01);
    strobe(pin_mux_pkg::CYC_IO_WR, 8'h04);
    strobe(pin_mux_pkg::CYC_NONE, 8'h07);
    wr(pin_mux_pkg::REG_CTRL, 8'h00);
  endtask
  task automatic t_port_a;
    wr(pin_mux_pkg::REG_PA_DIR, 8'hFF);
    wr(pin_mux_pkg::REG_PA_DATA, 8'hA5);
    look(2);
    chk("pa_o", 8'hA5, pa_o);
    chk("pa_oe", 8'hFF, pa_oe);
    @(posedge clk_sys);
    wr(pin_mux_pkg::REG_PA_DIR, 8'h00);
    mst_a_data <= 8'h3C;
    mst_drive_a <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(pin_mux_pkg::REG_PA_PIN, 8'h3C, "pa_pin");
    mst_drive_a <= 1'b0;
  endtask
  task automatic t_slave;
    wr(pin_mux_pkg::REG_CTRL, 8'h02);
    attn_req <= 1'b1;
    mst_addr <= 2'b10;
    look(8);
    chk("attn_n", 8'h00, {7'h00, pb_o[7]});
    chk("saddr", 8'h02, {6'h00, s_hi, s_lo});
    @(posedge clk_sys);
    mst_a_data <= 8'h96;
    mst_drive_a <= 1'b1;
    mst_wr_n <= 1'b0;
    look(8);
    chk("s_wr_n", 8'h00, {7'h00, s_wr_n});
    chk("s_wdata", 8'h96, slave_wr_data);
    @(posedge clk_sys);
    mst_wr_n <= 1'b1;
    mst_drive_a <= 1'b0;
    slave_rd_data <= 8'h5A;
    look(8);
    chk("pa_oe_idle", 8'h00, pa_oe);
    chk("s_rd_n_idle", 8'h01, {7'h00, s_rd_n});
    @(posedge clk_sys);
    mst_rd_n <= 1'b0;
    look(8);
    chk("pa_oe_rd", 8'hFF, pa_oe);
    chk("pa_o_rd", 8'h5A, pa_o);
    chk("s_rd_n", 8'h00, {7'h00, s_rd_n});
    @(posedge clk_sys);
    mst_rd_n <= 1'b1;
    look(8);
    chk("pa_oe_end", 8'h00, pa_oe);
    @(posedge clk_sys);
    attn_req <= 1'b0;
    wr(pin_mux_pkg::REG_CTRL, 8'h00);
  endtask
  task automatic t_port_b;
    wr(pin_mux_pkg::REG_PB_DATA, 8'hC0);
    sclk_peer <= 2'b01;
    mst_addr <= 2'b01;
    look(2);
    chk("pb_o76", 8'h03, {6'h00, pb_o[7:6]});
    repeat (6) @(posedge clk_sys);
    rd(pin_mux_pkg::REG_PB_DATA, 8'hDD, "pb_pins");
    wr(pin_mux_pkg::REG_CTRL, 8'h3C);
    sclk_a_out <= 1'b1;
    look(2);
    chk("pb_oe_clk", 8'hC3, pb_oe);
    chk("pb_sclk", 8'h02, {6'h00, pb_o[1:0]});
    @(posedge clk_sys);
    wr(pin_mux_pkg::REG_CTRL, 8'h0C);
    sclk_peer <= 2'b10;
    look(8);
    chk("sclk_in", 8'h02, {6'h00, sa_in, sb_in});
    @(posedge clk_sys);
    wr(pin_mux_pkg::REG_CTRL, 8'h00);
  endtask
  task automatic t_port_c;
    wr(pin_mux_pkg::REG_PC_DATA, 8'hFF);
    look(2);
    chk("pc_par", 8'h55, pc_o & pin_mux_pkg::PC_OUT_MASK);
    @(posedge clk_sys);
    wr(pin_mux_pkg::REG_PC_FUNC, 8'h55);
    ser_txd <= 4'b1001;
    look(2);
    chk("pc_ser", 8'h41, pc_o & pin_mux_pkg::PC_OUT_MASK);
    @(posedge clk_sys);
    wr(pin_mux_pkg::REG_PC_FUNC, 8'h04);
    pc_i <= 8'hA0;
    look(8);
    chk("pc_mix", 8'h51, pc_o & pin_mux_pkg::PC_OUT_MASK);
    chk("ser_rxd", 8'h03, {4'h0, ser_rxd});
    @(posedge clk_sys);
    rd(pin_mux_pkg::REG_PC_DATA, 8'hA0, "pc_pins");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end
  initial
  begin
    rst_n = 1'b0; io_cycle = pin_mux_pkg::CYC_NONE; attn_req = 1'b0;
    slave_rd_data = 8'h00; sclk_a_out = 1'b0; sclk_b_out = 1'b0; ser_txd = 4'h0;
    reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; pc_i = 8'h00;
    mst_drive_a = 1'b0; mst_a_data = 8'h00; mst_rd_n = 1'b1; mst_wr_n = 1'b1;
    mst_addr = 2'b00; sclk_peer = 2'b00;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_strobes();
    t_port_a();
    t_slave();
    t_port_b();
    t_port_c();
    test_done();
  end
endmodule
